// >>> opt_page_pkg.sv
// option page package: field layout, reset values, encodings, timing
// assumes: nothing beyond a systemverilog compiler
package opt_page_pkg;
  // ***********************************************
  // page layout (bit 31 is sent first)
  // ***********************************************
  localparam int page_w = 32;
  localparam int lock_w = 8;
  localparam int cfg_w = 24;
  localparam logic [7:0] lock_reset = 8'h80;
  // config field positions inside the 24 config bits, msb first order
  localparam int f_idlen_hi = 23;
  localparam int f_idlen_lo = 20;
  localparam int f_frame_en = 19;
  localparam int f_stop_val = 18;
  localparam int f_null_hi = 17;
  localparam int f_null_lo = 16;
  localparam int f_test = 15;
  localparam int f_pw_en = 14;
  localparam int f_tx_hi = 13;
  localparam int f_tx_lo = 8;
  localparam int f_rx_mult = 7;
  localparam int f_code_hi = 6;
  localparam int f_code_lo = 5;
  localparam int f_inv = 4;
  localparam int f_mod_hi = 3;
  localparam int f_mod_lo = 2;
  localparam int f_password_page_lock = 1;
  localparam int f_cfg_lock = 0;
  // shipped config: framing on, stop 1, rx x4, miller
  localparam logic [23:0] cfg_reset = 24'h0c00c0;
  // ***********************************************
  // encodings
  // ***********************************************
  localparam logic [1:0] code_nrz = 2'h0;
  localparam logic [1:0] code_manch = 2'h1;
  localparam logic [1:0] code_miller = 2'h2;
  localparam logic [1:0] mod_ask = 2'h0;
  localparam logic [1:0] mod_psk_ones = 2'h1;
  localparam logic [1:0] mod_psk_change = 2'h2;
  localparam logic [1:0] mod_subcarrier = 2'h3;
  localparam logic [1:0] null_cont = 2'h0;
  // ***********************************************
  // counts
  // ***********************************************
  localparam int id_base_bytes = 4;
  localparam int tx_step_clocks = 16;
  localparam int listen_bits = 8;
  localparam int password_page = 9;
  localparam int serial_page = 7;
  localparam int npages = 8;
  // mean null-frame spacing per selector value
  localparam logic [7:0] null_mean_8 = 8'h08;
  localparam logic [7:0] null_mean_32 = 8'h20;
  localparam logic [7:0] null_mean_128 = 8'h80;
  // serial command encoding, writes and read
  localparam logic [1:0] cmd_none = 2'h0;
  localparam logic [1:0] cmd_lock = 2'h1;
  localparam logic [1:0] cmd_cfg = 2'h2;
  localparam logic [1:0] cmd_read = 2'h3;
endpackage

// >>> opt_cfg_if.sv
// decoded option fields shared between page and timing helper
// assumes: one clock domain, driven by the page store
`timescale 1ns/1ps
interface opt_cfg_if;
  logic [5:0] tx_bit_period; // period selector
  logic rx_rate_multiplier; // rx x2 or x4
  logic [10:0] tx_clocks; // carrier clocks per tx bit
  logic [12:0] rx_clocks; // carrier clocks per rx bit
  modport src (output tx_bit_period, output rx_rate_multiplier, input tx_clocks, input rx_clocks);
  modport calc (input tx_bit_period, input rx_rate_multiplier, output tx_clocks, output rx_clocks);
endinterface

// >>> bit_rate_calc.sv
// bit-period arithmetic for transmit and receive
// assumes: fields come from the option page in the same clock domain
`timescale 1ns/1ps
module bit_rate_calc (
  opt_cfg_if.calc cfg
);
  // ***********************************************
  // rate arithmetic
  // ***********************************************
  localparam logic [10:0] step = 11'(opt_page_pkg::tx_step_clocks);
  // (value+1)*16 clocks per transmitted bit
  assign cfg.tx_clocks = (11'(cfg.tx_bit_period) + 11'h001) * step;
  // rx period is tx period times two or four
  assign cfg.rx_clocks = cfg.rx_rate_multiplier ? {cfg.tx_clocks, 2'h0} : {1'h0, cfg.tx_clocks, 1'h0};
endmodule

// >>> null_frame_gate.sv
// random null-frame decision for anti-collision
// assumes: frame_end pulses once per frame from the sequencer
`timescale 1ns/1ps
module null_frame_gate (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [1:0] null_sel,
  input wire logic frame_end,
  output logic send_next
);
  // ***********************************************
  // lfsr and spacing draw
  // ***********************************************
  logic [15:0] lfsr_reg; // free-running random source
  logic [8:0] wait_reg; // frames still to suppress, nine bits so 256 fits
  logic [8:0] mean; // selected mean spacing
  logic [8:0] draw; // uniform draw 1..2*mean
  // mean lookup for the selector
  always_comb begin
    case (null_sel)
      2'h1: mean = {1'b0, opt_page_pkg::null_mean_8};
      2'h2: mean = {1'b0, opt_page_pkg::null_mean_32};
      default: mean = {1'b0, opt_page_pkg::null_mean_128};
    endcase
  end
  // draw in 1..2*mean keeps the mean, max twice the mean
  // widened so the top draw of the 128 mean does not wrap to zero
  assign draw = ({1'b0, lfsr_reg[7:0]} & ((mean << 1) - 9'h001)) + 9'h001;
  // random source
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lfsr_reg <= 16'hace1;
    end else begin
      lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
    end
  end
  // frame counting, a frame is id plus listen window
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wait_reg <= 9'h000;
    end else if (frame_end) begin
      if (null_sel == opt_page_pkg::null_cont) begin
        wait_reg <= 9'h000;
      end else if (wait_reg <= 9'h001) begin
        wait_reg <= draw;
      end else begin
        wait_reg <= wait_reg - 9'h001;
      end
    end
  end
  // continuous mode always sends
  assign send_next = (null_sel == opt_page_pkg::null_cont) || (wait_reg <= 9'h001);
endmodule

// >>> option_page.sv
// option page store: lock byte and configuration bytes
// assumes: command decoder delivers 2-bit command and serial bits on clk,
// framing, encoder and modulator datapaths use the decoded outputs
`timescale 1ns/1ps
module option_page (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [1:0] cmd_start, // command decoded, one-cycle pulse
  input wire logic bit_valid, // serial bit strobe
  input wire logic bit_data, // serial bit, msb first
  input wire logic cmd_done, // end of command data
  input wire logic read_shift, // advance read shifter
  input wire logic [3:0] page_sel, // page targeted by a user write
  input wire logic frame_end, // end of listen window
  output logic read_bit, // serial read-back bit
  output logic write_done, // page store updated
  output logic write_refused, // write dropped: wrong bit count, or config write under config lock
  output logic [7:0] page_lock, // lock bits per user page
  output logic page_write_ok, // selected page may be written
  output logic [4:0] id_byte_count, // total id bytes
  output logic framing_bits_enable,
  output logic start_level, // start bit as sent
  output logic stop_level, // stop bit as sent
  output logic [1:0] null_frame_select,
  output logic send_this_frame, // frame not suppressed
  output logic test_mode_enable,
  output logic password_enable,
  output logic [3:0] password_page_index,
  output logic [10:0] tx_clocks_per_bit,
  output logic [12:0] rx_clocks_per_bit,
  output logic [1:0] line_code_select,
  output logic encoder_output_invert,
  output logic [1:0] modulation_select,
  output logic password_page_lock,
  output logic config_lock
);
  // ***********************************************
  // storage and shifting
  // ***********************************************
  typedef enum {st_idle, st_lock_in, st_cfg_in} wr_state_t;
  wr_state_t state_reg; // write sequencer state
  logic [7:0] page_write_lock_byte_reg; // lock byte
  logic [23:0] transponder_config_bytes_reg; // config bytes
  logic [23:0] shift_reg; // incoming serial bits
  logic [4:0] count_reg; // bits received so far
  logic [31:0] rd_reg; // read-back shifter
  logic send_raw; // from null-frame gate
  opt_cfg_if cfg_bus ();
  // fields to the rate helper
  assign cfg_bus.tx_bit_period = transponder_config_bytes_reg[opt_page_pkg::f_tx_hi:opt_page_pkg::f_tx_lo];
  assign cfg_bus.rx_rate_multiplier = transponder_config_bytes_reg[opt_page_pkg::f_rx_mult];
  bit_rate_calc rate_u (
    .cfg(cfg_bus)
  );
  null_frame_gate gate_u (
    .clk(clk),
    .rstn(rstn),
    .null_sel(transponder_config_bytes_reg[opt_page_pkg::f_null_hi:opt_page_pkg::f_null_lo]),
    .frame_end(frame_end),
    .send_next(send_raw)
  );
  // ***********************************************
  // write sequencer
  // ***********************************************
  // only the two dedicated commands open a write, no 32-bit path
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= st_idle;
    end else begin
      case (state_reg)
        st_idle: begin
          if (cmd_start == opt_page_pkg::cmd_lock) begin
            state_reg <= st_lock_in;
          end else if (cmd_start == opt_page_pkg::cmd_cfg) begin
            state_reg <= st_cfg_in;
          end
        end
        st_lock_in, st_cfg_in: begin
          if (cmd_done) begin
            state_reg <= st_idle;
          end
        end
        default: state_reg <= st_idle;
      endcase
    end
  end
  // serial bits shifted in msb first
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shift_reg <= 24'h000000;
      count_reg <= 5'h00;
    end else if (state_reg == st_idle) begin
      count_reg <= 5'h00;
    end else if (bit_valid && count_reg < 5'(opt_page_pkg::cfg_w)) begin
      shift_reg <= {shift_reg[22:0], bit_data};
      count_reg <= count_reg + 5'h01;
    end
  end
  // lock byte written by lock command only, and never by config
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      page_write_lock_byte_reg <= opt_page_pkg::lock_reset;
    end else if (state_reg == st_lock_in && cmd_done && count_reg == 5'(opt_page_pkg::lock_w)) begin
      // lock byte stays writable under config lock
      // locks only ever set, a set lock holds until reset
      page_write_lock_byte_reg <= page_write_lock_byte_reg | shift_reg[7:0];
    end
  end
  // config bytes written by config command unless locked
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      transponder_config_bytes_reg <= opt_page_pkg::cfg_reset;
    end else if (state_reg == st_cfg_in && cmd_done && count_reg == 5'(opt_page_pkg::cfg_w)
                 && !transponder_config_bytes_reg[opt_page_pkg::f_cfg_lock]) begin
      transponder_config_bytes_reg <= shift_reg;
    end
  end
  // completion and refusal pulses
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      write_done <= 1'b0;
      write_refused <= 1'b0;
    end else begin
      write_done <= 1'b0;
      write_refused <= 1'b0;
      if (state_reg == st_lock_in && cmd_done) begin
        write_done <= (count_reg == 5'(opt_page_pkg::lock_w));
        write_refused <= (count_reg != 5'(opt_page_pkg::lock_w));
      end else if (state_reg == st_cfg_in && cmd_done) begin
        // refused when locked or short
        if (count_reg == 5'(opt_page_pkg::cfg_w) && !transponder_config_bytes_reg[opt_page_pkg::f_cfg_lock]) begin
          write_done <= 1'b1;
        end else begin
          write_refused <= 1'b1;
        end
      end
    end
  end
  // ***********************************************
  // read back
  // ***********************************************
  // lock byte then config, msb first, same order as written
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_reg <= 32'h00000000;
    end else if (cmd_start == opt_page_pkg::cmd_read) begin
      rd_reg <= {page_write_lock_byte_reg, transponder_config_bytes_reg};
    end else if (read_shift) begin
      rd_reg <= {rd_reg[30:0], 1'b0};
    end
  end
  // ***********************************************
  // decoded outputs, all registered
  // ***********************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      read_bit <= 1'b0;
      page_lock <= opt_page_pkg::lock_reset;
      page_write_ok <= 1'b0;
      id_byte_count <= 5'(opt_page_pkg::id_base_bytes);
      framing_bits_enable <= 1'b1;
      start_level <= 1'b0;
      stop_level <= 1'b1;
      null_frame_select <= opt_page_pkg::null_cont;
      send_this_frame <= 1'b1;
      test_mode_enable <= 1'b0;
      password_enable <= 1'b0;
      password_page_index <= 4'(opt_page_pkg::password_page);
      tx_clocks_per_bit <= 11'(opt_page_pkg::tx_step_clocks);
      rx_clocks_per_bit <= 13'(opt_page_pkg::tx_step_clocks * 4);
      line_code_select <= opt_page_pkg::code_miller;
      encoder_output_invert <= 1'b0;
      modulation_select <= opt_page_pkg::mod_ask;
      password_page_lock <= 1'b0;
      config_lock <= 1'b0;
    end else begin
      read_bit <= rd_reg[31];
      page_lock <= page_write_lock_byte_reg;
      // page writable only if unlocked, password does not override
      if (page_sel == 4'(opt_page_pkg::password_page)) begin
        page_write_ok <= !transponder_config_bytes_reg[opt_page_pkg::f_password_page_lock];
      end else if (page_sel < 4'(opt_page_pkg::npages)) begin
        page_write_ok <= !page_write_lock_byte_reg[page_sel[2:0]];
      end else begin
        page_write_ok <= 1'b0;
      end
      // four base bytes plus extra count
      id_byte_count <= 5'(opt_page_pkg::id_base_bytes)
        + {1'b0, transponder_config_bytes_reg[opt_page_pkg::f_idlen_hi:opt_page_pkg::f_idlen_lo]};
      framing_bits_enable <= transponder_config_bytes_reg[opt_page_pkg::f_frame_en];
      // start is complement of stop, both flipped by inversion
      stop_level <= transponder_config_bytes_reg[opt_page_pkg::f_stop_val]
        ^ transponder_config_bytes_reg[opt_page_pkg::f_inv];
      start_level <= ~(transponder_config_bytes_reg[opt_page_pkg::f_stop_val]
        ^ transponder_config_bytes_reg[opt_page_pkg::f_inv]);
      null_frame_select <= transponder_config_bytes_reg[opt_page_pkg::f_null_hi:opt_page_pkg::f_null_lo];
      send_this_frame <= send_raw;
      // test bit only reported, kept zero by the writer
      test_mode_enable <= transponder_config_bytes_reg[opt_page_pkg::f_test];
      password_enable <= transponder_config_bytes_reg[opt_page_pkg::f_pw_en];
      password_page_index <= 4'(opt_page_pkg::password_page);
      tx_clocks_per_bit <= cfg_bus.tx_clocks;
      rx_clocks_per_bit <= cfg_bus.rx_clocks;
      // 11 behaves as nrz like 00
      if (transponder_config_bytes_reg[opt_page_pkg::f_code_hi:opt_page_pkg::f_code_lo] == 2'h3) begin
        line_code_select <= opt_page_pkg::code_nrz;
      end else begin
        line_code_select <= transponder_config_bytes_reg[opt_page_pkg::f_code_hi:opt_page_pkg::f_code_lo];
      end
      encoder_output_invert <= transponder_config_bytes_reg[opt_page_pkg::f_inv];
      modulation_select <= transponder_config_bytes_reg[opt_page_pkg::f_mod_hi:opt_page_pkg::f_mod_lo];
      password_page_lock <= transponder_config_bytes_reg[opt_page_pkg::f_password_page_lock];
      config_lock <= transponder_config_bytes_reg[opt_page_pkg::f_cfg_lock];
    end
  end
endmodule

// >>> option_page_chk.sv
// checker: port relations of the option page store
// assumes: bound to option_page, one clock domain on clk with rstn
`timescale 1ns/1ps
module option_page_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cmd_done,
  input wire logic [3:0] page_sel,
  input wire logic write_done,
  input wire logic write_refused,
  input wire logic [7:0] page_lock,
  input wire logic page_write_ok,
  input wire logic [4:0] id_byte_count,
  input wire logic start_level,
  input wire logic stop_level,
  input wire logic [3:0] password_page_index,
  input wire logic [10:0] tx_clocks_per_bit,
  input wire logic [12:0] rx_clocks_per_bit,
  input wire logic [1:0] line_code_select,
  input wire logic [1:0] modulation_select,
  input wire logic password_page_lock,
  input wire logic config_lock
);
  // ************************************
  // assertions, all on clk
  // ************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_locks_set_only: assert property (page_lock[7] && (page_lock & $past(page_lock)) == $past(page_lock))
    else $error("lock bit cleared");
  a_answer_in_time: assert property (cmd_done |-> ##[1:2] (write_done || write_refused))
    else $error("no answer after command end");
  a_answer_one_pulse: assert property ((write_done || write_refused) |->
    !(write_done && write_refused) ##1 !(write_done || write_refused)) else $error("answer not a single pulse");
  a_tx_rate_span: assert property (tx_clocks_per_bit[3:0] == 4'h0 && tx_clocks_per_bit >= 11'h010
    && tx_clocks_per_bit <= 11'h400) else $error("tx clocks per bit off grid");
  a_rx_rate_ratio: assert property (rx_clocks_per_bit == {1'b0, tx_clocks_per_bit, 1'b0}
    || rx_clocks_per_bit == {tx_clocks_per_bit, 2'h0}) else $error("rx period not tx times 2 or 4");
  a_id_len_range: assert property (id_byte_count >= 5'h04 && id_byte_count <= 5'h13)
    else $error("id length out of range");
  a_start_stop_opp: assert property (start_level != stop_level)
    else $error("start bit equals stop bit");
  a_cfg_lock_frozen: assert property ($past(config_lock) |-> config_lock && $stable(line_code_select)
    && $stable(modulation_select) && $stable(tx_clocks_per_bit) && $stable(id_byte_count))
    else $error("locked configuration changed");
  a_user_page_ok: assert property (($past(rstn) && $past(page_sel) < 4'h8 && $stable(page_lock))
    |-> page_write_ok == !page_lock[$past(page_sel[2:0])]) else $error("page write permission wrong");
  a_pw_page_ok: assert property (($past(rstn) && $past(page_sel) == 4'h9 && $stable(password_page_lock))
    |-> page_write_ok == !password_page_lock) else $error("password page permission wrong");
  a_pw_page_nine: assert property (password_page_index == 4'h9)
    else $error("password page index wrong");
endmodule
bind option_page option_page_chk u_option_page_chk (.clk(clk), .rstn(rstn), .cmd_done(cmd_done),
  .page_sel(page_sel), .write_done(write_done), .write_refused(write_refused), .page_lock(page_lock),
  .page_write_ok(page_write_ok), .id_byte_count(id_byte_count), .start_level(start_level),
  .stop_level(stop_level), .password_page_index(password_page_index), .tx_clocks_per_bit(tx_clocks_per_bit),
  .rx_clocks_per_bit(rx_clocks_per_bit), .line_code_select(line_code_select),
  .modulation_select(modulation_select), .password_page_lock(password_page_lock), .config_lock(config_lock));

// >>> reader_model.sv
// reader/writer model: sends write commands and reads the page back
// assumes: drives on the falling edge of clk, design samples on rising
`timescale 1ns/1ps
module reader_model (
  input wire logic clk,
  input wire logic read_bit,
  input wire logic write_done,
  input wire logic write_refused,
  output logic [1:0] cmd_start,
  output logic bit_valid,
  output logic bit_data,
  output logic cmd_done,
  output logic read_shift
);
  // ************************************
  // command tasks
  // ************************************
  initial begin
    cmd_start = 2'h0;
    bit_valid = 1'b0;
    bit_data = 1'b0;
    cmd_done = 1'b0;
    read_shift = 1'b0;
  end
  // one write command; st = {done, refused}, zero on timeout
  task automatic write_cmd(input logic [1:0] code, input logic [31:0] v, input int n, output logic [1:0] st);
    int i;
    if (code == opt_page_pkg::cmd_cfg) v[opt_page_pkg::f_test] = 1'b0;
    @(negedge clk) cmd_start = code;
    @(negedge clk) cmd_start = opt_page_pkg::cmd_none;
    for (i = n - 1; i >= 0; i--) begin
      bit_valid = 1'b1; // msb first
      bit_data = v[i];
      @(negedge clk);
    end
    bit_valid = 1'b0;
    bit_data = ~bit_data; // released line shows no stale bit
    cmd_done = 1'b1;
    @(negedge clk) cmd_done = 1'b0;
    st = 2'h0;
    for (i = 0; i < 4 && st == 2'h0; i++) begin
      st = {write_done, write_refused};
      if (st == 2'h0) @(negedge clk);
    end
  endtask
  // read command, then one shift per cycle
  task automatic read_page(output logic [31:0] d);
    int i;
    @(negedge clk) cmd_start = opt_page_pkg::cmd_read;
    @(negedge clk) cmd_start = opt_page_pkg::cmd_none;
    @(negedge clk) d[31] = read_bit;
    read_shift = 1'b1;
    @(negedge clk);
    for (i = 30; i >= 0; i--) @(negedge clk) d[i] = read_bit;
    read_shift = 1'b0;
  endtask
endmodule

// >>> rfid_option_page_config_tb_top.sv
// testbench: write, lock and read back the option page
// assumes: reader_model drives commands, bench drives reset, page_sel, frame_end
`timescale 1ns/1ps
module rfid_option_page_config_tb_top;
  logic clk, rstn, bit_valid, bit_data, cmd_done, read_shift, frame_end, read_bit, write_done, write_refused;
  logic page_write_ok, framing_bits_enable, start_level, stop_level, send_this_frame, test_mode_enable;
  logic password_enable, encoder_output_invert, password_page_lock, config_lock;
  logic [1:0] cmd_start, null_frame_select, line_code_select, modulation_select;
  logic [3:0] page_sel, password_page_index;
  logic [7:0] page_lock;
  logic [4:0] id_byte_count;
  logic [10:0] tx_clocks_per_bit;
  logic [12:0] rx_clocks_per_bit;
  logic [23:0] cfgs [4] = '{24'hf07f7c, 24'h1d00a4, 24'h7a205a, 24'h0f4180}; // every code and mode
  logic [31:0] rd;
  int miscompares = 0;
  int tests_run = 0;
  int i, p, sent;
  // ************************************
  // clock, instances
  // ************************************
  initial clk = 1'b0;
  always #25 clk = ~clk;
  option_page u_option_page (.clk(clk), .rstn(rstn), .cmd_start(cmd_start), .bit_valid(bit_valid),
    .bit_data(bit_data), .cmd_done(cmd_done), .read_shift(read_shift), .page_sel(page_sel), .frame_end(frame_end),
    .read_bit(read_bit), .write_done(write_done), .write_refused(write_refused), .page_lock(page_lock),
    .page_write_ok(page_write_ok), .id_byte_count(id_byte_count), .framing_bits_enable(framing_bits_enable),
    .start_level(start_level), .stop_level(stop_level), .null_frame_select(null_frame_select),
    .send_this_frame(send_this_frame), .test_mode_enable(test_mode_enable), .password_enable(password_enable),
    .password_page_index(password_page_index), .tx_clocks_per_bit(tx_clocks_per_bit),
    .rx_clocks_per_bit(rx_clocks_per_bit), .line_code_select(line_code_select),
    .encoder_output_invert(encoder_output_invert), .modulation_select(modulation_select),
    .password_page_lock(password_page_lock), .config_lock(config_lock));
  reader_model u_reader_model (.clk(clk), .read_bit(read_bit), .write_done(write_done),
    .write_refused(write_refused), .cmd_start(cmd_start), .bit_valid(bit_valid), .bit_data(bit_data),
    .cmd_done(cmd_done), .read_shift(read_shift));
  // ************************************
  // helpers
  // ************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // write and compare the {done, refused} answer
  task automatic wr(input logic [1:0] c, input logic [31:0] v, input int n, input logic [1:0] exp);
    logic [1:0] st;
    u_reader_model.write_cmd(c, v, n, st);
    if (st === 2'h0) begin
      miscompares++;
      results;
    end
    check(st, exp);
    repeat (3) @(negedge clk);
  endtask
  // decoded fields against a config value
  task automatic check_cfg(input logic [23:0] c);
    check(id_byte_count, {28'h0, c[23:20]} + 32'h4);
    check({framing_bits_enable, start_level, stop_level}, {c[19], ~(c[18] ^ c[4]), c[18] ^ c[4]});
    check({null_frame_select, test_mode_enable, password_enable}, c[17:14]);
    check(tx_clocks_per_bit, ({26'h0, c[13:8]} + 32'h1) * 32'h10);
    check(rx_clocks_per_bit, ({26'h0, c[13:8]} + 32'h1) * (c[7] ? 32'h40 : 32'h20));
    check(line_code_select, c[6:5] == 2'h3 ? opt_page_pkg::code_nrz : c[6:5]);
    check({encoder_output_invert, modulation_select}, c[4:2]);
    check({password_page_lock, config_lock}, c[1:0]);
  endtask
  // permission of every page after a page_sel change
  task automatic pages;
    for (p = 0; p < 11; p++) begin
      page_sel = p[3:0];
      repeat (2) @(negedge clk);
      check(page_write_ok, p < 8 ? !page_lock[p] : (p == 9 && !password_page_lock));
    end
  endtask
  // ************************************
  // main sequence
  // ************************************
  initial begin
    rstn = 1'b0;
    page_sel = 4'h0;
    frame_end = 1'b0;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    check_cfg(opt_page_pkg::cfg_reset);
    check({page_lock, password_page_index, send_this_frame}, {8'h80, 4'h9, 1'b1});
    u_reader_model.read_page(rd);
    check(rd, {8'h80, opt_page_pkg::cfg_reset});
    $display("test reset_values done");
    wr(opt_page_pkg::cmd_lock, 32'h05, 8, 2'h2);
    check(page_lock, 8'h85);
    check_cfg(opt_page_pkg::cfg_reset);
    wr(opt_page_pkg::cmd_lock, 32'h02, 7, 2'h1);
    pages;
    $display("test lock_byte done");
    for (i = 0; i < 4; i++) begin
      wr(opt_page_pkg::cmd_cfg, {8'h0, cfgs[i]}, 24, 2'h2);
      check_cfg(cfgs[i]);
      check(page_lock, 8'h85);
      pages;
      sent = 0;
      // enough frames that a leftover spacing of up to 64 still ends in a send
      repeat (140) begin
        frame_end = 1'b1;
        @(negedge clk);
        frame_end = 1'b0;
        sent += (send_this_frame === 1'b1);
        repeat (2) @(negedge clk);
      end
      check(cfgs[i][17:16] == 2'h0 ? sent == 140 : (sent < 140 && sent > 0), 1'b1);
    end
    $display("test config_table done");
    wr(opt_page_pkg::cmd_cfg, 32'h1d00a5, 24, 2'h2);
    wr(opt_page_pkg::cmd_cfg, 32'hf07f7c, 24, 2'h1);
    check_cfg(24'h1d00a5);
    wr(opt_page_pkg::cmd_lock, 32'h40, 8, 2'h2);
    u_reader_model.read_page(rd);
    check(rd, 32'hc51d00a5);
    $display("test config_lock done");
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    check(page_lock, 8'h80);
    check_cfg(opt_page_pkg::cfg_reset);
    $display("test second_reset done");
    results;
  end
endmodule
